/* File: src/dnfc_consts.vh */
`ifndef DNFC_CONSTS_VH
`define DNFC_CONSTS_VH

// register offsets
`define DNFC_ADDR_CAL_LO      8'h3C
`define DNFC_ADDR_CAL_HI      8'h3D
`define DNFC_ADDR_CTRL        8'h50
`define DNFC_ADDR_XO_RAW      8'h51
`define DNFC_ADDR_PLL_FREQ    8'h52
`define DNFC_ADDR_HOLD_FREQ   8'h53
`define DNFC_ADDR_LIMIT       8'h54
`define DNFC_ADDR_MON_FREQ    8'h55

// reset values
`define DNFC_CAL_LO_RST       8'h99
`define DNFC_CAL_HI_RST       8'h99
`define DNFC_CTRL_RST         8'h00

// control field positions
`define DNFC_CTRL_MON_SEL     0

// calibration scale: word 0 is -771 ppm, 16'hFFFF about +514 ppm
`define DNFC_CAL_ZERO_PPM     16'h9999
`define DNFC_PPM_PER_LSB_E9   32'd19622900
// one lsb of the word is this many 2^-40 parts of the frequency word
`define DNFC_CAL_SCALE_K      16'd21576
`define DNFC_CAL_SCALE_SH     40

`endif

/* File: src/dnfc_cal_scale.v */
`timescale 1ns/1ps
`default_nettype none
`include "dnfc_consts.vh"

module dnfc_cal_scale #(
	parameter W = 32
) (
	// clock and reset
	input  wire         sys_clk,
	input  wire         resetn,
	// calibration word and raw reference
	input  wire [15:0]  cal_word,
	input  wire [W-1:0] raw_freq,
	// calibrated reference
	output reg  [W-1:0] cal_freq_reg
);
	wire signed [16:0] ofs;
	wire signed [W+47:0] prod;
	wire [W-1:0] adj;

	// signed distance of the unsigned word from the zero point
	assign ofs  = $signed({1'b0, cal_word}) -
		$signed({1'b0, `DNFC_CAL_ZERO_PPM});
	// signed product keeps the sign for words below the zero point
	assign prod = $signed({1'b0, raw_freq}) * ofs *
		$signed({1'b0, `DNFC_CAL_SCALE_K});
	assign adj  = prod[W+`DNFC_CAL_SCALE_SH-1:`DNFC_CAL_SCALE_SH];

	always @(posedge sys_clk) begin
		if (!resetn)
			cal_freq_reg <= {W{1'b0}};
		else
			cal_freq_reg <= raw_freq + adj;
	end
endmodule

`default_nettype wire

/* File: src/dnfc_top.v */
// What this block does
// - The calibration word shifts the assumed crystal frequency from about -771 ppm to about +514 ppm.
// - The offset is applied only inside the digital PLL reference path.
// - The reported PLL frequency reflects the calibration offset.
// - The holdover frequency and the PLL offset limit are taken relative to the calibrated crystal.
// - Input frequency monitors use the uncalibrated crystal frequency.
// - With the monitor clock select set, the monitors use the calibrated PLL clock.
// - The lower byte is a read/write register resetting to 8'h99.
`timescale 1ns/1ps
`default_nettype none
`include "dnfc_consts.vh"

module dnfc_top #(
	parameter FW = 32
) (
	// clock and reset
	input  wire          sys_clk,
	input  wire          resetn,
	// register port
	input  wire [7:0]    reg_addr,
	input  wire [7:0]    reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [7:0]    reg_rdata,
	// raw crystal frequency word and pll inputs
	input  wire [FW-1:0] xo_freq,
	input  wire [FW-1:0] pll_track,
	input  wire [FW-1:0] hold_rel,
	input  wire [FW-1:0] limit_rel,
	// outputs toward pll and monitors
	output reg  [FW-1:0] pll_ref_freq,
	output reg  [FW-1:0] reported_pll_freq,
	output reg  [FW-1:0] hold_freq,
	output reg  [FW-1:0] pll_offset_limit,
	output reg  [FW-1:0] mon_ref_freq,
	output reg  [15:0]   cal_word
);
	reg  [7:0]    cal_lo_reg;
	reg  [7:0]    cal_hi_reg;
	reg  [7:0]    ctrl_reg;
	wire [FW-1:0] cal_freq;

	function [7:0] sel_byte;
		input [FW-1:0] v;
		input [1:0]    b;
		begin
			sel_byte = v[b*8 +: 8];
		end
	endfunction

	dnfc_cal_scale #(
		.W (FW)
	) u_scale (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.cal_word     ({cal_hi_reg, cal_lo_reg}),
		.raw_freq     (xo_freq),
		.cal_freq_reg (cal_freq)
	);

	// register writes
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cal_lo_reg <= `DNFC_CAL_LO_RST;
			cal_hi_reg <= `DNFC_CAL_HI_RST;
			ctrl_reg   <= `DNFC_CTRL_RST;
		end else if (reg_wr) begin
			case (reg_addr)
			`DNFC_ADDR_CAL_LO: begin
				cal_lo_reg <= reg_wdata;
			end
			`DNFC_ADDR_CAL_HI: begin
				cal_hi_reg <= reg_wdata;
			end
			`DNFC_ADDR_CTRL: begin
				ctrl_reg <= {7'h00, reg_wdata[`DNFC_CTRL_MON_SEL]};
			end
			default: begin
			end
			endcase
		end
	end

	// datapath
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cal_word          <= {`DNFC_CAL_HI_RST, `DNFC_CAL_LO_RST};
			pll_ref_freq      <= {FW{1'b0}};
			reported_pll_freq <= {FW{1'b0}};
			hold_freq         <= {FW{1'b0}};
			pll_offset_limit  <= {FW{1'b0}};
			mon_ref_freq      <= {FW{1'b0}};
		end else begin
			cal_word          <= {cal_hi_reg, cal_lo_reg};
			pll_ref_freq      <= cal_freq;
			reported_pll_freq <= cal_freq + pll_track;
			hold_freq         <= cal_freq + hold_rel;
			pll_offset_limit  <= cal_freq + limit_rel;
			if (ctrl_reg[`DNFC_CTRL_MON_SEL])
				mon_ref_freq <= reported_pll_freq;
			else
				mon_ref_freq <= xo_freq;
		end
	end

	// register reads, data in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
			`DNFC_ADDR_CAL_LO:    reg_rdata <= cal_lo_reg;
			`DNFC_ADDR_CAL_HI:    reg_rdata <= cal_hi_reg;
			`DNFC_ADDR_CTRL:      reg_rdata <= ctrl_reg;
			`DNFC_ADDR_XO_RAW:    reg_rdata <= sel_byte(xo_freq, 2'd0);
			`DNFC_ADDR_PLL_FREQ:  reg_rdata <= sel_byte(reported_pll_freq, 2'd0);
			`DNFC_ADDR_HOLD_FREQ: reg_rdata <= sel_byte(hold_freq, 2'd0);
			`DNFC_ADDR_LIMIT:     reg_rdata <= sel_byte(pll_offset_limit, 2'd0);
			`DNFC_ADDR_MON_FREQ:  reg_rdata <= sel_byte(mon_ref_freq, 2'd0);
			default:              reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end
endmodule

`default_nettype wire

/* File: test/dnfc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dnfc_checker #(parameter FW = 32) (
	// watched ports
	input wire logic          sys_clk,
	input wire logic          resetn,
	input wire logic [7:0]    reg_addr,
	input wire logic [7:0]    reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [7:0]    reg_rdata,
	input wire logic [FW-1:0] pll_track,
	input wire logic [FW-1:0] pll_ref_freq,
	input wire logic [FW-1:0] reported_pll_freq,
	input wire logic [15:0]   cal_word
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_lo_write: assert property (reg_wr && reg_addr == 8'h3C
		|-> ##2 cal_word[7:0] == $past(reg_wdata, 2)) else $error("lo byte");
	chk_hi_write: assert property (reg_wr && reg_addr == 8'h3D
		|-> ##2 cal_word[15:8] == $past(reg_wdata, 2)) else $error("hi byte");
	chk_idle_zero: assert property (!reg_rd
		|=> reg_rdata == 8'h00) else $error("idle data");
	chk_bad_read: assert property (reg_rd && reg_addr == 8'h7F
		|=> reg_rdata == 8'h00) else $error("unmapped data");
	chk_hi_read: assert property (!reg_wr ##1 reg_rd && reg_addr == 8'h3D
		|=> reg_rdata == cal_word[15:8]) else $error("hi read");
	chk_lo_read: assert property (!reg_wr ##1 reg_rd && reg_addr == 8'h3C
		|=> reg_rdata == cal_word[7:0]) else $error("lo read");
	chk_pll_sum: assert property (($stable(pll_ref_freq) &&
		$stable(pll_track))[*3] |-> reported_pll_freq == pll_ref_freq + pll_track)
		else $error("pll sum");
	chk_word_hold: assert property (!reg_wr ##1 !reg_wr
		|=> $stable(cal_word)) else $error("word moved");
	cover property (reg_wr && reg_addr == 8'h3D);
	cover property (reg_rd && reg_addr == 8'h3C);
	cover property (cal_word == 16'h0000);
endmodule
bind dnfc_top dnfc_checker #(.FW(FW)) u_chk (.sys_clk, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pll_track, .pll_ref_freq,
	.reported_pll_freq, .cal_word);
`default_nettype wire

/* File: test/dnfc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dnfc_top_test;
	logic        sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [31:0] xo_freq = 32'h1000_0000, pll_track = 32'h40;
	logic [31:0] hold_rel = 32'h20, limit_rel = 32'h10;
	logic [31:0] pll_ref_freq, reported_pll_freq, hold_freq;
	logic [31:0] pll_offset_limit, mon_ref_freq;
	logic [15:0] cal_word;
	int          error_cnt = 0, check_count = 0;
	dnfc_top uut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .xo_freq, .pll_track, .hold_rel, .limit_rel, .pll_ref_freq,
		.reported_pll_freq, .hold_freq, .pll_offset_limit, .mon_ref_freq,
		.cal_word);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task settle;
		repeat (5) @(posedge sys_clk);
		#1;
	endtask
	task t_base;
		settle;
		chk(cal_word, 16'h9999);
		rd(8'h3C, 8'h99);
		chk(pll_ref_freq, xo_freq);
		chk(reported_pll_freq, xo_freq + pll_track);
		chk(hold_freq, xo_freq + hold_rel);
		chk(pll_offset_limit, xo_freq + limit_rel);
		chk(mon_ref_freq, xo_freq);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'h01);
		settle;
		chk(mon_ref_freq, xo_freq + pll_track);
		wr(8'h7F, 8'h55);
		rd(8'h7F, 8'h00);
	endtask
	task t_word;
		wr(8'h3C, 8'h34);
		wr(8'h3D, 8'h12);
		settle;
		chk(cal_word, 16'h1234);
		rd(8'h3D, 8'h12);
	endtask
	task t_range;
		wr(8'h3D, 8'h00);
		wr(8'h3C, 8'h00);
		settle;
		chk(pll_ref_freq < xo_freq, 32'h1);
		chk((xo_freq - pll_ref_freq) inside {[32'd206900:32'd207300]}, 32'h1);
		chk(mon_ref_freq, reported_pll_freq);
		wr(8'h50, 8'h00);
		wr(8'h3D, 8'hFF);
		wr(8'h3C, 8'hFF);
		settle;
		chk(pll_ref_freq > xo_freq, 32'h1);
		chk((pll_ref_freq - xo_freq) inside {[32'd137900:32'd138300]}, 32'h1);
		chk(mon_ref_freq, xo_freq);
	endtask
	task end_of_test;
		if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial forever #5 sys_clk = ~sys_clk;
	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		t_base;
		t_word;
		t_range;
		end_of_test;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		end_of_test;
	end
endmodule
`default_nettype wire
